// ===== rtcaw_event_logic.v
// RTC alarm, watchdog, power-fail flags and interrupt pin driver with APB registers
//
// The APB slave port is this design's own decision.

`include "rtcaw_consts.vh"

module rtcaw_event_logic (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [21:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Oscillator and power monitor pins
    input wire oscTickPin,
    input wire oscRunningPin,
    input wire mainPowerPin,
    input wire powerFailPin,
    // Timekeeping core, same clock
    input wire [7:0] curSecond,
    input wire [7:0] curMinute,
    input wire [7:0] curHour,
    input wire [7:0] curDate,
    input wire oscFailSet,
    input wire [5:0] storedTimeout,
    // Interrupt pin
    output reg intOut,
    output reg intOe,
    // Alarm values as applied
    output wire [31:0] alarmApplied
);

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    // Returns {hit, register index low nibble}
    function [4:0] decodeAddr;
        input [21:0] addr;
        begin
            decodeAddr = {(addr[21:6] == 16'hFFFF) && (addr[1:0] == 2'h0), addr[5:2]};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    reg [3:0] syncA;
    reg [3:0] syncB;
    reg tickPrev;
    reg pfPrev;
    wire tickSync = syncB[0];
    wire oscRunning = syncB[1];
    wire mainPower = syncB[2];
    wire pfSync = syncB[3];

    // Synchronisers and edge history keep sampling through reset,
    // so a pin already high at release does not count as an edge
    always @(posedge sys_clk) begin
        syncA <= {powerFailPin, mainPowerPin, oscRunningPin, oscTickPin};
        syncB <= syncA;
        tickPrev <= tickSync;
        pfPrev <= pfSync;
    end

    // Watchdog only sees ticks while the oscillator runs
    wire tick = tickSync & ~tickPrev & oscRunning;
    wire pfEvent = pfSync & ~pfPrev;

    ////////////////////////////////////////////////////////////////////////
    // APB decode

    wire [4:0] dec = decodeAddr(paddr);
    wire [19:0] regIdx = {16'hFFFF, dec[3:0]};
    wire accessDone = psel & penable;
    wire allowed = mainPower;
    wire regHit = dec[4] && (regIdx == `RTCAW_IDX_EVENT_FLAGS
                  || (regIdx >= `RTCAW_IDX_ALARM_SECONDS && regIdx <= `RTCAW_IDX_WATCHDOG_CONTROL));
    wire wrOk = accessDone & pwrite & regHit & allowed;
    wire rdFlags = accessDone & ~pwrite & allowed & dec[4] && (regIdx == `RTCAW_IDX_EVENT_FLAGS);
    wire wrFlags = wrOk && (regIdx == `RTCAW_IDX_EVENT_FLAGS);
    wire wrIntCtl = wrOk && (regIdx == `RTCAW_IDX_INTERRUPT_CONTROL);
    wire wrWdog = wrOk && (regIdx == `RTCAW_IDX_WATCHDOG_CONTROL);
    wire wrAlarm = wrOk && (regIdx >= `RTCAW_IDX_ALARM_SECONDS) && (regIdx <= `RTCAW_IDX_ALARM_DATE);
    wire [1:0] almSel = dec[1:0] - 2'h2;

    reg errFlag;
    assign pready = 1'b1;
    assign pslverr = psel & penable & errFlag;

    ////////////////////////////////////////////////////////////////////////
    // Registers

    reg [7:0] flags;
    reg [7:0] intCtl;
    reg [5:0] wdTimeout;
    reg [7:0] almShadow [0:3];
    reg [7:0] almActive [0:3];
    reg freezePrev;
    reg [5:0] wdCount;
    reg loadPending;
    reg alarmPrev;
    integer i;

    wire freeze = flags[`RTCAW_FLG_FREEZE];
    // Reset image of the flag byte
    wire [7:0] rstFlags = `RTCAW_RST_FLAGS;

    ////////////////////////////////////////////////////////////////////////
    // Alarm comparator

    wire [7:0] curField [0:3];
    assign curField[0] = curSecond;
    assign curField[1] = curMinute;
    assign curField[2] = curHour;
    assign curField[3] = curDate;

    wire [3:0] fieldOk;
    wire [3:0] maskBits;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gField
            assign maskBits[g] = almActive[g][`RTCAW_ALM_MASK];
            // Field matches when excluded or equal
            assign fieldOk[g] = maskBits[g] | (almActive[g][6:0] == curField[g][6:0]);
            assign alarmApplied[8*g+7:8*g] = almActive[g];
        end
    endgenerate

    wire alarmMatch = (maskBits != 4'hF) & (&fieldOk);
    // One event per match, not one per cycle of the matching second
    wire alarmEvent = alarmMatch & ~alarmPrev;

    ////////////////////////////////////////////////////////////////////////
    // Watchdog

    wire wdEnabled = (wdTimeout != 6'h00);
    wire wdStrobe = wrWdog & pwdata[`RTCAW_WD_STROBE];
    wire [5:0] newTimeout = (wrWdog & ~pwdata[`RTCAW_WD_LOCK]) ? pwdata[5:0] : wdTimeout;
    wire wdEvent = wdEnabled & tick & ~wdStrobe & ~loadPending & (wdCount == 6'h01);

    always @(posedge sys_clk) begin
        if (rst) begin
            wdTimeout <= 6'h00;
            wdCount <= 6'h00;
            loadPending <= 1'b1;
        end else if (loadPending) begin
            // Stored timeout copied in the first cycle after every reset, counting starts
            wdTimeout <= storedTimeout;
            wdCount <= storedTimeout;
            loadPending <= 1'b0;
        end else begin
            wdTimeout <= newTimeout;
            if (wdStrobe) begin
                wdCount <= newTimeout;
            end else if (wdEvent) begin
                wdCount <= wdTimeout;
            end else if (tick && wdEnabled && wdCount != 6'h00) begin
                wdCount <= wdCount - 6'h01;
            end else if (wdEnabled && wdCount == 6'h00) begin
                wdCount <= wdTimeout;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags, control and alarm registers

    always @(posedge sys_clk) begin
        if (rst) begin
            flags[7:5] <= rstFlags[7:5];
            // Oscillator fail flag follows its own detector
            flags[`RTCAW_FLG_OSCFAIL] <= oscFailSet;
            flags[3:0] <= rstFlags[3:0];
            intCtl <= `RTCAW_RST_INTCTL;
            freezePrev <= 1'b0;
            alarmPrev <= 1'b0;
            for (i = 0; i < 4; i = i + 1) begin
                almShadow[i] <= `RTCAW_RST_ALARM;
                almActive[i] <= `RTCAW_RST_ALARM;
            end
        end else begin
            freezePrev <= freeze;
            alarmPrev <= alarmMatch;
            // Set wins over the read clear
            flags[`RTCAW_FLG_WATCHDOG] <= wdEvent | (flags[`RTCAW_FLG_WATCHDOG] & ~rdFlags);
            flags[`RTCAW_FLG_ALARM] <= alarmEvent | (flags[`RTCAW_FLG_ALARM] & ~rdFlags);
            flags[`RTCAW_FLG_POWERFAIL] <= pfEvent | (flags[`RTCAW_FLG_POWERFAIL] & ~rdFlags);
            if (oscFailSet) begin
                flags[`RTCAW_FLG_OSCFAIL] <= 1'b1;
            end else if (wrFlags && freeze && !pwdata[`RTCAW_FLG_OSCFAIL]) begin
                flags[`RTCAW_FLG_OSCFAIL] <= 1'b0;
            end
            flags[3] <= 1'b0;
            if (wrFlags) begin
                flags[2:0] <= pwdata[2:0];
            end
            if (wrIntCtl) begin
                intCtl <= pwdata[7:0] & 8'hEC;
            end
            if (wrAlarm) begin
                almShadow[almSel] <= pwdata[7:0];
            end
            // Alarm values applied when freeze drops
            if (freezePrev && !freeze) begin
                for (i = 0; i < 4; i = i + 1) begin
                    almActive[i] <= almShadow[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB read data, registered in the setup phase

    reg [7:0] rdByte;
    always @* begin
        rdByte = 8'h00;
        if (dec[4]) begin
            case (dec[3:0])
                4'h0: rdByte = flags;
                4'h2, 4'h3, 4'h4, 4'h5: rdByte = almShadow[almSel];
                4'h6: rdByte = intCtl;
                4'h7: rdByte = {2'h0, wdTimeout};
                default: rdByte = 8'h00;
            endcase
        end
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            prdata <= 32'h00000000;
            errFlag <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= allowed ? {24'h000000, rdByte} : 32'h00000000;
            errFlag <= ~regHit | ~allowed;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt driver

    // Pulse length in ticks, cut to the counter width
    localparam [31:0] PULSE_TICKS_W = `RTCAW_PULSE_TICKS;
    localparam [2:0] PULSE_TICKS = PULSE_TICKS_W[2:0];
    reg [2:0] pulseCount;
    reg levelActive;
    reg pulseActive;

    wire srcActive = (flags[`RTCAW_FLG_WATCHDOG] & intCtl[`RTCAW_IC_WDOG_EN])
                   | (flags[`RTCAW_FLG_ALARM] & intCtl[`RTCAW_IC_ALARM_EN])
                   | (flags[`RTCAW_FLG_POWERFAIL] & intCtl[`RTCAW_IC_PFAIL_EN]);
    wire newEnabled = (wdEvent & intCtl[`RTCAW_IC_WDOG_EN])
                    | (alarmEvent & intCtl[`RTCAW_IC_ALARM_EN])
                    | (pfEvent & intCtl[`RTCAW_IC_PFAIL_EN]);
    wire pulseMode = intCtl[`RTCAW_IC_PULSE];

    always @(posedge sys_clk) begin
        if (rst) begin
            pulseCount <= 3'h0;
            pulseActive <= 1'b0;
            levelActive <= 1'b0;
        end else begin
            levelActive <= ~pulseMode & srcActive & ~rdFlags & mainPower;
            if (!pulseMode || rdFlags || !mainPower) begin
                pulseActive <= 1'b0;
                pulseCount <= 3'h0;
            end else if (!pulseActive && newEnabled) begin
                pulseActive <= 1'b1;
                pulseCount <= PULSE_TICKS;
            end else if (pulseActive && tick) begin
                if (pulseCount == 3'h1) begin
                    pulseActive <= 1'b0;
                end
                pulseCount <= pulseCount - 3'h1;
            end
        end
    end

    wire intActive = (levelActive | pulseActive) & mainPower;

    always @(posedge sys_clk) begin
        if (rst) begin
            intOut <= 1'b0;
            intOe <= 1'b0;
        end else if (intCtl[`RTCAW_IC_POLARITY]) begin
            // Push-pull active high, driven only on main power
            intOut <= intActive;
            intOe <= mainPower;
        end else begin
            // Open drain active low
            intOut <= 1'b0;
            intOe <= intActive;
        end
    end

endmodule // rtcaw_event_logic

// ===== rtcaw_consts.vh
// Register indices, field positions, reset values and timing for the RTC event logic
`ifndef RTCAW_CONSTS_VH
`define RTCAW_CONSTS_VH

// Register indices; byte address is four times the index
`define RTCAW_IDX_EVENT_FLAGS 20'hFFFF0
`define RTCAW_IDX_ALARM_SECONDS 20'hFFFF2
`define RTCAW_IDX_ALARM_MINUTES 20'hFFFF3
`define RTCAW_IDX_ALARM_HOURS 20'hFFFF4
`define RTCAW_IDX_ALARM_DATE 20'hFFFF5
`define RTCAW_IDX_INTERRUPT_CONTROL 20'hFFFF6
`define RTCAW_IDX_WATCHDOG_CONTROL 20'hFFFF7

// event_flags fields
`define RTCAW_FLG_WATCHDOG 7
`define RTCAW_FLG_ALARM 6
`define RTCAW_FLG_POWERFAIL 5
`define RTCAW_FLG_OSCFAIL 4
`define RTCAW_FLG_CAL 2
`define RTCAW_FLG_FREEZE 1
`define RTCAW_FLG_READ 0

// interrupt_control fields
`define RTCAW_IC_WDOG_EN 7
`define RTCAW_IC_ALARM_EN 6
`define RTCAW_IC_PFAIL_EN 5
`define RTCAW_IC_POLARITY 3
`define RTCAW_IC_PULSE 2

// watchdog_control fields
`define RTCAW_WD_STROBE 7
`define RTCAW_WD_LOCK 6

// Alarm field mask bit; set excludes the field from the match
`define RTCAW_ALM_MASK 7

// Reset values
`define RTCAW_RST_FLAGS 8'h00
`define RTCAW_RST_INTCTL 8'h08
`define RTCAW_RST_ALARM 8'h80

// Timing: tick period and interrupt pulse width
`define RTCAW_TICK_US 31250
`define RTCAW_PULSE_MS 200
`define RTCAW_PULSE_TICKS ((`RTCAW_PULSE_MS * 1000) / `RTCAW_TICK_US)

`endif

// ===== rtcaw_props.sv
// Checker for the RTC event logic ports
module rtcaw_props (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [21:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Power and interrupt pin
    input wire mainPowerPin,
    input wire intOut,
    input wire intOe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ic;
    wire acc = psel && penable && pready;
    wire flagRd = acc && !pwrite && !pslverr && paddr == 22'h3FFFC0;
    wire act = intOe && (intOut == ic[3]);
    // Shadow of interrupt_control for polarity and mode
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ic <= 8'h08;
        end else if (acc && pwrite && !pslverr && paddr == 22'h3FFFD8) begin
            ic <= pwdata[7:0];
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence offPower;
        !mainPowerPin [*5];
    endsequence
    sequence ctlSteady;
        ic == $past(ic) && ic == $past(ic, 2);
    endsequence
    reset_quiet_a: assert property (disable iff (1'b0) rst |=> !intOe && !intOut && prdata == 32'h0)
        else $error("outputs not quiet after reset");
    unmapped_err_a: assert property (acc && paddr == 22'h3FFFC4 |-> pslverr)
        else $error("unmapped access not refused");
    backup_refuse_a: assert property (offPower ##0 acc |-> pslverr)
        else $error("access accepted on backup power");
    backup_noint_a: assert property (offPower |-> !act)
        else $error("interrupt active on backup power");
    open_drain_a: assert property (ctlSteady ##0 !ic[3] |-> !(intOe && intOut))
        else $error("open drain pin driven high");
    irq_needs_en_a: assert property ($rose(act) && ic == $past(ic, 3) |-> |ic[7:5])
        else $error("interrupt without enable");
    read_clear_a: assert property (flagRd && act |-> ##[1:3] !act)
        else $error("flags read did not clear pin");
    level_hold_a: assert property (act && !ic[2] && !flagRd && !$past(flagRd) && !$past(flagRd, 2)
        && mainPowerPin && $past(mainPowerPin, 3) && ic == $past(ic, 2) |=> act)
        else $error("level interrupt dropped early");
endmodule // rtcaw_props

// ===== rtcaw_host_model.sv
// Host side of the interrupt line: pull-up and power-up ignore window
module rtcaw_host_model #(
    parameter int RECALL_WAIT = 20
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Interrupt pin
    input wire intOut,
    input wire intOe,
    // Host view
    output logic pinLevel,
    output logic pinValid
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    assign pinLevel = intOe ? intOut : 1'b1;
    assign pinValid = (cnt >= RECALL_WAIT);
    always @(posedge sys_clk) begin
        if (rst) begin
            cnt <= 0;
        end else if (cnt < RECALL_WAIT) begin
            cnt <= cnt + 1;
        end
    end
endmodule // rtcaw_host_model

// ===== tb_top.sv
// Testbench for the RTC event logic
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [21:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic oscTickPin = 0, oscRunningPin = 0, mainPowerPin = 1, powerFailPin = 0, oscFailSet = 0;
    logic [7:0] curSecond = 0, st, al;
    logic [5:0] storedTimeout = 0;
    logic [9:0] expQ[$];
    logic [9:0] e;
    wire [31:0] prdata, alarmApplied;
    wire pready, pslverr, intOut, intOe, pinLevel, pinValid;
    int seed = 32'hb9cc;
    int n_mismatch = 0, tests_run = 0;
    always #2 sys_clk = ~sys_clk;
    rtcaw_event_logic dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .oscTickPin(oscTickPin), .oscRunningPin(oscRunningPin), .mainPowerPin(mainPowerPin),
        .powerFailPin(powerFailPin), .curSecond(curSecond), .curMinute(8'h00), .curHour(8'h00),
        .curDate(8'h00), .oscFailSet(oscFailSet), .storedTimeout(storedTimeout), .intOut(intOut), .intOe(intOe),
        .alarmApplied(alarmApplied));
    rtcaw_host_model host (.sys_clk(sys_clk), .rst(rst), .intOut(intOut), .intOe(intOe),
        .pinLevel(pinLevel), .pinValid(pinValid));
    ////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [19:0] idx, input logic [7:0] d, input logic [8:0] ex);
        int n;
        expQ.push_back({!wr, ex});
        psel <= 1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge sys_clk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_mismatch++;
            stop_test();
        end else begin
            psel <= 0;
            penable <= 0;
            @(posedge sys_clk);
        end
    endtask
    task automatic rd(input logic [19:0] idx, input logic [8:0] ex);
        apb(1'b0, idx, 8'h00, ex);
    endtask
    task automatic wr(input logic [19:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d, 9'h000);
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            oscTickPin <= 1;
            repeat (4) @(posedge sys_clk);
            oscTickPin <= 0;
            repeat (4) @(posedge sys_clk);
        end
    endtask
    task automatic pin(input logic v);
        repeat (4) @(posedge sys_clk);
        chk("pin", {pinValid, pinLevel}, {1'b1, v});
    endtask
    ////////////////////////////////////////
    always @(posedge sys_clk) begin
        if (psel && penable && pready) begin
            e = expQ.pop_front();
            chk("pslverr", pslverr, e[8]);
            if (e[9]) chk("prdata", prdata, {24'h0, e[7:0]});
        end
    end
    initial begin
        st = 8'(2 + ($random(seed) & 3));
        al = 8'(1 + ($random(seed) & 8'h3F));
        storedTimeout <= st[5:0];
        repeat (6) @(posedge sys_clk);
        rst <= 0;
        repeat (30) @(posedge sys_clk);
        rd(20'hFFFF0, 9'h000);
        rd(20'hFFFF2, 9'h080);
        rd(20'hFFFF6, 9'h008);
        rd(20'hFFFF7, {1'b0, st});
        rd(20'hFFFF1, 9'h100);
        tick(st + 2);
        rd(20'hFFFF0, 9'h000);
        oscRunningPin <= 1;
        repeat (4) @(posedge sys_clk);
        repeat (3) begin
            tick(st - 1);
            wr(20'hFFFF7, 8'hC0);
        end
        rd(20'hFFFF0, 9'h000);
        wr(20'hFFFF6, 8'h88);
        tick(st);
        pin(1);
        rd(20'hFFFF0, 9'h080);
        pin(0);
        wr(20'hFFFF7, 8'h00);
        wr(20'hFFFF7, 8'h45);
        rd(20'hFFFF7, 9'h000);
        tick(st + 1);
        rd(20'hFFFF0, 9'h000);
        wr(20'hFFFF6, 8'h44);
        wr(20'hFFFF0, 8'h02);
        wr(20'hFFFF2, al);
        chk("applied", alarmApplied, 32'h80808080);
        wr(20'hFFFF0, 8'h00);
        repeat (2) @(posedge sys_clk);
        chk("applied", alarmApplied, {24'h808080, al});
        curSecond <= al;
        pin(0);
        rd(20'hFFFF0, 9'h040);
        pin(1);
        curSecond <= 0;
        repeat (3) @(posedge sys_clk);
        curSecond <= al;
        tick(5);
        pin(0);
        tick(1);
        pin(1);
        rd(20'hFFFF0, 9'h040);
        wr(20'hFFFF0, 8'h02);
        wr(20'hFFFF2, al | 8'h80);
        wr(20'hFFFF0, 8'h00);
        curSecond <= 0;
        repeat (3) @(posedge sys_clk);
        curSecond <= al;
        repeat (4) @(posedge sys_clk);
        rd(20'hFFFF0, 9'h000);
        powerFailPin <= 1;
        pin(1);
        rd(20'hFFFF0, 9'h020);
        oscFailSet <= 1;
        @(posedge sys_clk);
        oscFailSet <= 0;
        rd(20'hFFFF0, 9'h010);
        rd(20'hFFFF0, 9'h010);
        rst <= 1;
        repeat (2) @(posedge sys_clk);
        rst <= 0;
        repeat (6) @(posedge sys_clk);
        rd(20'hFFFF0, 9'h000);
        rd(20'hFFFF7, {1'b0, st});
        mainPowerPin <= 0;
        repeat (6) @(posedge sys_clk);
        rd(20'hFFFF0, 9'h100);
        mainPowerPin <= 1;
        repeat (6) @(posedge sys_clk);
        stop_test();
    end
endmodule // tb_top

bind rtcaw_event_logic rtcaw_props u_props (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mainPowerPin(mainPowerPin), .intOut(intOut), .intOe(intOe));
